// *** design/pmj_defs.svh ***
`ifndef PMJ_DEFS_SVH
`define PMJ_DEFS_SVH
// =====================================================
// Register map (byte address, word index = address / 4)
`define PMJ_ADDR_W 8
`define PMJ_REG_CTRL 8'h00
`define PMJ_REG_JOG_SPEED 8'h04
`define PMJ_REG_TERM_FORCE 8'h08
`define PMJ_REG_TERM_LEVEL 8'h0c
`define PMJ_REG_DISPLAY 8'h10
`define PMJ_REG_STATUS 8'h14
`define PMJ_REG_CNT_A 8'h18
`define PMJ_REG_CNT_B 8'h1c
`define PMJ_REG_ENC_OPT 8'h20
// =====================================================
// Control fields
`define PMJ_CTRL_POSMODE_A 0
`define PMJ_CTRL_POSMODE_B 1
`define PMJ_CTRL_OT_DISABLE 2
// =====================================================
// Jog speed setting
`define PMJ_JOG_SPEED_MAX 16'd6000
`define PMJ_JOG_SPEED_RST 16'd500
// =====================================================
// Aux function and monitor item numbering
`define PMJ_FN_JOG 4'h2
`define PMJ_FN_MAX 4'hf
`define PMJ_MON_MAX 5'h10
`define PMJ_MON_REF_CNT 5'h0a
// =====================================================
// Terminal indices and encoder option code
`define PMJ_TERM_SON 0
`define PMJ_TERM_FOT 1
`define PMJ_TERM_ROT 2
`define PMJ_TERM_ABS 3
`define PMJ_ENC_AS_INC 4'h2
// =====================================================
// Timing
`define PMJ_CLK_MHZ 200
`define PMJ_HOLD_MS 1000
`define PMJ_DEB_US 5
`define PMJ_HOLD_CYC (`PMJ_HOLD_MS * 1000 * `PMJ_CLK_MHZ)
`define PMJ_DEB_CYC (`PMJ_DEB_US * `PMJ_CLK_MHZ)
`endif

// *** design/pmj_pkg.sv ***
package pmj_pkg;
   // =====================================================
   // Panel states
   typedef enum logic [5:0] {
      PMJ_MON_LIST = 6'h01,
      PMJ_MON_SHOW = 6'h02,
      PMJ_AUX_LIST = 6'h04,
      PMJ_JOG_OFF = 6'h08,
      PMJ_JOG_ON = 6'h10,
      PMJ_IDLE = 6'h20
   } pmj_state_t;

   typedef struct packed {
      logic mode;
      logic set;
      logic up;
      logic down;
      logic shift;
   } pmj_keys_t;

   typedef struct packed {
      logic servo_on;
      logic fwd;
      logic rev;
      logic [15:0] speed;
   } pmj_motor_t;

   typedef struct packed {
      logic [4:0] item;
      logic show_value;
      logic aux;
      logic [3:0] fn;
      logic [15:0] value;
      logic dp0;
   } pmj_disp_t;
endpackage : pmj_pkg

// *** design/pmj_key_debounce.sv ***
`timescale 1ns/1ps
`include "pmj_defs.svh"
module pmj_key_debounce #(
   parameter int DEB_CYC = `PMJ_DEB_CYC
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic key_i,
   output logic level_o,
   output logic press_o
);
   logic [15:0] cnt_reg;
   // =====================================================
   // Stable-level filter
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= 16'h0000;
         level_o <= 1'b0;
         press_o <= 1'b0;
      end
      else if (ce_i)
      begin
         press_o <= 1'b0;
         if (key_i == level_o)
            cnt_reg <= 16'h0000;
         else if (cnt_reg == 16'(DEB_CYC - 1))
         begin
            cnt_reg <= 16'h0000;
            level_o <= key_i;
            press_o <= key_i;
         end
         else
            cnt_reg <= cnt_reg + 16'h0001;
      end
   end
endmodule : pmj_key_debounce

// *** design/pmj_ref_counter.sv ***
`timescale 1ns/1ps
module pmj_ref_counter #(
   parameter int WIDTH = 32
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic pos_mode_i,
   input wire logic pulse_i,
   input wire logic dir_i,
   output logic [WIDTH-1:0] count_o
);
   // =====================================================
   // Reference pulse accumulation
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         count_o <= '0;
      else if (ce_i && pos_mode_i && pulse_i)
         count_o <= dir_i ? count_o - WIDTH'(1) : count_o + WIDTH'(1);
   end
endmodule : pmj_ref_counter

// *** design/pmj_panel.sv ***
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "pmj_defs.svh"
module pmj_panel #(
   parameter int HOLD_CYC = `PMJ_HOLD_CYC,
   parameter int DEB_CYC = `PMJ_DEB_CYC,
   parameter int CNT_W = 32
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire pmj_pkg::pmj_keys_t keys_i,
   input wire logic [1:0] ref_pulse_i,
   input wire logic [1:0] ref_dir_i,
   input wire logic [3:0] term_i,
   input wire logic [`PMJ_ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output pmj_pkg::pmj_disp_t disp_o,
   output pmj_pkg::pmj_motor_t motor_o,
   output logic servo_enable_o,
   output logic abs_request_needed_o
);
   pmj_pkg::pmj_state_t state_reg;
   pmj_pkg::pmj_state_t state_next;
   logic [4:0] lvl;
   logic [4:0] prs;
   logic [31:0] hold_reg;
   logic hold_done_reg;
   logic axis_b_reg;
   logic high_half_reg;
   logic [4:0] item_reg;
   logic [3:0] fn_reg;
   logic [2:0] ctrl_reg;
   logic [15:0] jog_speed_reg;
   logic [3:0] force_reg;
   logic [3:0] force_lvl_reg;
   logic [3:0] enc_opt_reg;
   logic [3:0] term_eff;
   logic [CNT_W-1:0] cnt_a;
   logic [CNT_W-1:0] cnt_b;
   logic [CNT_W-1:0] cnt_sel;
   logic hold_fire;
   logic ot_fwd_ok;
   logic ot_rev_ok;
   logic in_jog;
   logic [15:0] wspeed;

   // =====================================================
   // Key conditioning
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_key
         pmj_key_debounce #(
            .DEB_CYC(DEB_CYC)
         ) u_deb (
            .clock_i(clock_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .key_i(keys_i[gi]),
            .level_o(lvl[gi]),
            .press_o(prs[gi])
         );
      end
   endgenerate
   // Bit order follows the struct: mode=4 set=3 up=2 down=1 shift=0

   // =====================================================
   // Reference counters, one per axis
   pmj_ref_counter #(
      .WIDTH(CNT_W)
   ) u_cnt_a (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pos_mode_i(ctrl_reg[`PMJ_CTRL_POSMODE_A]),
      .pulse_i(ref_pulse_i[0]),
      .dir_i(ref_dir_i[0]),
      .count_o(cnt_a)
   );
   pmj_ref_counter #(
      .WIDTH(CNT_W)
   ) u_cnt_b (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pos_mode_i(ctrl_reg[`PMJ_CTRL_POSMODE_B]),
      .pulse_i(ref_pulse_i[1]),
      .dir_i(ref_dir_i[1]),
      .count_o(cnt_b)
   );

   // =====================================================
   // Mode key hold timer
   // The long hold fires once per press and the release gives no event; the
   // press edge itself raises prs[4], which the monitor states ignore.
   assign hold_fire = lvl[4] && !hold_done_reg && (hold_reg == 32'(HOLD_CYC - 1));
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hold_reg <= 32'h0000_0000;
         hold_done_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         if (!lvl[4])
         begin
            hold_reg <= 32'h0000_0000;
            hold_done_reg <= 1'b0;
         end
         else if (hold_fire)
            hold_done_reg <= 1'b1;
         else if (!hold_done_reg)
            hold_reg <= hold_reg + 32'h0000_0001;
      end
   end

   // =====================================================
   // Terminal forcing and overtravel
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_term
         assign term_eff[gi] = force_reg[gi] ? force_lvl_reg[gi] : term_i[gi];
      end
   endgenerate
   // Inhibit inputs are ON (permit) when asserted; disabling is void in jog,
   // servo off included, so the servo cannot be enabled past a limit
   assign in_jog = (state_reg == pmj_pkg::PMJ_JOG_OFF) || (state_reg == pmj_pkg::PMJ_JOG_ON);
   assign ot_fwd_ok = term_eff[`PMJ_TERM_FOT] ||
                      (ctrl_reg[`PMJ_CTRL_OT_DISABLE] && !in_jog);
   assign ot_rev_ok = term_eff[`PMJ_TERM_ROT] ||
                      (ctrl_reg[`PMJ_CTRL_OT_DISABLE] && !in_jog);

   // =====================================================
   // Panel state machine
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         pmj_pkg::PMJ_IDLE:
            if (prs[4])
               state_next = pmj_pkg::PMJ_MON_LIST;
         pmj_pkg::PMJ_MON_LIST:
            if (hold_fire)
               state_next = pmj_pkg::PMJ_AUX_LIST;
            else if (prs[3])
               state_next = pmj_pkg::PMJ_MON_SHOW;
         pmj_pkg::PMJ_MON_SHOW:
            if (hold_fire)
               state_next = pmj_pkg::PMJ_AUX_LIST;
            else if (prs[3])
               state_next = pmj_pkg::PMJ_MON_LIST;
         pmj_pkg::PMJ_AUX_LIST:
            if (prs[3] && fn_reg == `PMJ_FN_JOG)
               state_next = pmj_pkg::PMJ_JOG_OFF;
         pmj_pkg::PMJ_JOG_OFF:
            if (prs[3])
               state_next = pmj_pkg::PMJ_AUX_LIST;
            else if (prs[4])
               state_next = pmj_pkg::PMJ_JOG_ON;
         pmj_pkg::PMJ_JOG_ON:
            if (prs[3])
               state_next = pmj_pkg::PMJ_AUX_LIST;
            else if (prs[4])
               state_next = pmj_pkg::PMJ_JOG_OFF;
         default:
            state_next = pmj_pkg::PMJ_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         state_reg <= pmj_pkg::PMJ_MON_LIST;
      else if (ce_i)
         state_reg <= state_next;
   end

   // =====================================================
   // Monitor selection
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         axis_b_reg <= 1'b0;
         high_half_reg <= 1'b0;
         item_reg <= `PMJ_MON_REF_CNT;
      end
      else if (ce_i)
      begin
         if (state_reg == pmj_pkg::PMJ_MON_LIST)
         begin
            if (prs[3])
            begin
               axis_b_reg <= 1'b0;
               high_half_reg <= 1'b0;
            end
            else if (prs[2] && item_reg != `PMJ_MON_MAX)
               item_reg <= item_reg + 5'h01;
            else if (prs[1] && item_reg != 5'h00)
               item_reg <= item_reg - 5'h01;
         end
         else if (state_reg == pmj_pkg::PMJ_MON_SHOW)
         begin
            if (prs[2] || prs[1])
            begin
               axis_b_reg <= 1'b1;
               high_half_reg <= 1'b0;
            end
            else if (prs[0])
               high_half_reg <= 1'b1;
         end
      end
   end

   // =====================================================
   // Aux function number
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         fn_reg <= 4'h0;
      else if (ce_i)
      begin
         if (hold_fire && (state_reg == pmj_pkg::PMJ_MON_LIST ||
                           state_reg == pmj_pkg::PMJ_MON_SHOW))
            fn_reg <= 4'h0;
         else if (state_reg == pmj_pkg::PMJ_AUX_LIST)
         begin
            if (prs[2] && fn_reg != `PMJ_FN_MAX)
               fn_reg <= fn_reg + 4'h1;
            else if (prs[1] && fn_reg != 4'h0)
               fn_reg <= fn_reg - 4'h1;
         end
      end
   end

   // =====================================================
   // Register file
   // Over-range speed writes saturate rather than wrap.
   assign wspeed = (wdata_i[15:0] > `PMJ_JOG_SPEED_MAX) ? `PMJ_JOG_SPEED_MAX : wdata_i[15:0];
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_reg <= 3'h0;
         jog_speed_reg <= `PMJ_JOG_SPEED_RST;
         force_reg <= 4'h0;
         force_lvl_reg <= 4'h0;
         enc_opt_reg <= 4'h0;
      end
      else if (ce_i && wr_i)
      begin
         unique case (addr_i)
            `PMJ_REG_CTRL: ctrl_reg <= wdata_i[2:0];
            `PMJ_REG_JOG_SPEED: jog_speed_reg <= wspeed;
            `PMJ_REG_TERM_FORCE: force_reg <= wdata_i[3:0];
            `PMJ_REG_TERM_LEVEL: force_lvl_reg <= wdata_i[3:0];
            `PMJ_REG_ENC_OPT: enc_opt_reg <= wdata_i[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_o <= 32'h0000_0000;
      else if (ce_i)
      begin
         rdata_o <= 32'h0000_0000;
         if (rd_i)
         begin
            unique case (addr_i)
               `PMJ_REG_CTRL: rdata_o <= {29'h0, ctrl_reg};
               `PMJ_REG_JOG_SPEED: rdata_o <= {16'h0, jog_speed_reg};
               `PMJ_REG_TERM_FORCE: rdata_o <= {28'h0, force_reg};
               `PMJ_REG_TERM_LEVEL: rdata_o <= {28'h0, force_lvl_reg};
               `PMJ_REG_DISPLAY: rdata_o <= {16'h0, disp_o.value};
               `PMJ_REG_STATUS: rdata_o <= {22'h0, term_eff, state_reg};
               `PMJ_REG_CNT_A: rdata_o <= 32'(cnt_a);
               `PMJ_REG_CNT_B: rdata_o <= 32'(cnt_b);
               `PMJ_REG_ENC_OPT: rdata_o <= {28'h0, enc_opt_reg};
               default: rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // =====================================================
   // Outputs
   assign cnt_sel = axis_b_reg ? cnt_b : cnt_a;
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         disp_o <= '0;
         motor_o <= '0;
         servo_enable_o <= 1'b0;
         abs_request_needed_o <= 1'b1;
      end
      else if (ce_i)
      begin
         disp_o.item <= item_reg;
         disp_o.show_value <= (state_reg == pmj_pkg::PMJ_MON_SHOW);
         disp_o.aux <= (state_reg == pmj_pkg::PMJ_AUX_LIST) ||
                       (state_reg == pmj_pkg::PMJ_JOG_OFF) ||
                       (state_reg == pmj_pkg::PMJ_JOG_ON);
         disp_o.fn <= fn_reg;
         disp_o.value <= high_half_reg ? cnt_sel[31:16] : cnt_sel[15:0];
         disp_o.dp0 <= axis_b_reg;
         motor_o.servo_on <= (state_reg == pmj_pkg::PMJ_JOG_ON);
         motor_o.fwd <= (state_reg == pmj_pkg::PMJ_JOG_ON) && lvl[2] && !lvl[1] &&
                        ot_fwd_ok;
         motor_o.rev <= (state_reg == pmj_pkg::PMJ_JOG_ON) && lvl[1] && !lvl[2] &&
                        ot_rev_ok;
         motor_o.speed <= jog_speed_reg;
         servo_enable_o <= term_eff[`PMJ_TERM_SON] && ot_fwd_ok && ot_rev_ok;
         abs_request_needed_o <= (enc_opt_reg != `PMJ_ENC_AS_INC);
      end
   end
endmodule : pmj_panel

// *** test/pmj_panel_model.sv ***
`timescale 1ns/1ps
// =====================================================
// Panel keys and controller terminals
module pmj_panel_model (
   input wire logic clock_i,
   output pmj_pkg::pmj_keys_t keys_o,
   output logic [3:0] term_o
);
   logic [4:0] key_reg = 5'h00;
   assign keys_o = key_reg;
   // Servo-on and both permits ON, no reference pulses
   initial term_o = 4'h7;
   task automatic key(input int k, input logic lvl);
      @(posedge clock_i);
      key_reg[k] <= lvl;
   endtask : key
   // Contact bounce first, so a single press must act once
   task automatic press(input int k, input int n);
      key(k, 1'b1);
      key(k, 1'b0);
      key(k, 1'b1);
      repeat (n) @(posedge clock_i);
      key_reg[k] <= 1'b0;
      repeat (6) @(posedge clock_i);
   endtask : press
   task automatic set_term(input logic [3:0] v);
      @(posedge clock_i);
      term_o <= v;
   endtask : set_term
endmodule : pmj_panel_model

// *** test/pmj_panel_props.sv ***
`timescale 1ns/1ps
module pmj_panel_props #(
   parameter int HOLD_CYC = 20,
   parameter int DEB_CYC = 2
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire pmj_pkg::pmj_keys_t keys_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire pmj_pkg::pmj_disp_t disp_o,
   input wire pmj_pkg::pmj_motor_t motor_o
);
   // Debounce plus state and output stages, with margin
   localparam int LAT = DEB_CYC + 6;
   logic [7:0] since [5];
   logic [31:0] mode_run;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // =====================================================
   // Cycles since each key was last high, saturating
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      for (int i = 0; i < 5; i++)
      begin
         if (rst_i)
            since[i] <= 8'hff;
         else if (keys_i[i])
            since[i] <= 8'h00;
         else if (since[i] != 8'hff)
            since[i] <= since[i] + 8'h01;
      end
   end
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         mode_run <= 32'h0;
      else
         mode_run <= keys_i.mode ? mode_run + 32'h1 : 32'h0;
   end
   sequence s_no_read;
      (ce_i && !rd_i) ##1 1'b1;
   endsequence
   // =====================================================
   // Assertions
   rdata_idle_a: assert property (s_no_read |-> rdata_o == 32'h0)
      else $error("read data not zero outside a read");
   hold_freeze_a: assert property (!ce_i |=> $stable(disp_o) && $stable(motor_o))
      else $error("outputs moved while clock enable low");
   speed_max_a: assert property (motor_o.speed <= 16'h1770)
      else $error("jog speed above maximum");
   value_axis_a: assert property ($rose(disp_o.show_value) |-> !disp_o.dp0)
      else $error("value display did not start on axis A");
   value_exit_a: assert property ($fell(disp_o.show_value) |->
      since[3] <= LAT || since[4] <= LAT)
      else $error("value display left without a key");
   aux_hold_a: assert property ($rose(disp_o.aux) |-> mode_run >= HOLD_CYC)
      else $error("aux mode entered without long mode hold");
   servo_on_a: assert property ($rose(motor_o.servo_on) |-> since[4] <= LAT)
      else $error("servo on without mode key");
   servo_off_a: assert property ($fell(motor_o.servo_on) |->
      since[4] <= LAT || since[3] <= LAT)
      else $error("servo off without mode or select key");
   jog_fwd_a: assert property (motor_o.fwd |->
      motor_o.servo_on && !motor_o.rev && since[2] <= LAT)
      else $error("forward drive without up key and servo on");
   jog_rev_a: assert property (motor_o.rev |-> motor_o.servo_on && since[1] <= LAT)
      else $error("reverse drive without down key and servo on");
endmodule : pmj_panel_props
bind pmj_panel pmj_panel_props #(
   .HOLD_CYC(HOLD_CYC),
   .DEB_CYC(DEB_CYC)
) i_pmj_panel_props (
   .clock_i(clock_i),
   .rst_i(rst_i),
   .ce_i(ce_i),
   .keys_i(keys_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .disp_o(disp_o),
   .motor_o(motor_o)
);

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "pmj_defs.svh"
module tb_top;
   localparam logic [63:0] MV = 64'h41_ffff;
   localparam logic [63:0] MF = 64'h1e_0000;
   localparam logic [63:0] MM = 64'h7000_0000_0000;
   localparam logic [63:0] MS = 64'h0fff_f000_0000;
   localparam logic [63:0] SE = 64'h1_0000_0000_0000;
   localparam logic [63:0] AR = 64'h8000_0000_0000;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   pmj_pkg::pmj_keys_t keys_i;
   logic [1:0] ref_pulse_i = 2'h0;
   logic [1:0] ref_dir_i = 2'h0;
   logic [3:0] term_i;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic look_s = 1'b0;
   logic rd_d = 1'b0;
   logic lk_d = 1'b0;
   logic [31:0] rdata_o;
   pmj_pkg::pmj_disp_t disp_o;
   pmj_pkg::pmj_motor_t motor_o;
   logic servo_enable_o;
   logic abs_request_needed_o;
   logic [127:0] exp_q [$];
   logic [127:0] ent;
   int n_errors = 0;
   int compares = 0;
   int n;
   logic [15:0] s;
   initial forever #2.5 clock_i = ~clock_i;
   pmj_panel #(.HOLD_CYC(20), .DEB_CYC(2)) i_pmj_panel (.clock_i(clock_i),
      .rst_i(rst_i), .ce_i(ce_i), .keys_i(keys_i), .ref_pulse_i(ref_pulse_i),
      .ref_dir_i(ref_dir_i), .term_i(term_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .disp_o(disp_o), .motor_o(motor_o),
      .servo_enable_o(servo_enable_o), .abs_request_needed_o(abs_request_needed_o));
   pmj_panel_model i_pmj_panel_model (.clock_i(clock_i), .keys_o(keys_i), .term_o(term_i));
   // =====================================================
   // Bus, reference pulse, display and result tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clock_i);
      exp_q.push_back({32'h0, m, 32'h0, e});
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
   endtask : rd
   // Outputs are levels, so let key and register effects settle first
   task automatic look(input logic [63:0] e, input logic [63:0] m);
      repeat (6) @(posedge clock_i);
      exp_q.push_back({m, e});
      look_s <= 1'b1;
      @(posedge clock_i);
      look_s <= 1'b0;
   endtask : look
   task automatic pulse(input logic [1:0] p, input logic [1:0] d);
      @(posedge clock_i);
      ref_pulse_i <= p;
      ref_dir_i <= d;
      @(posedge clock_i);
      ref_pulse_i <= 2'h0;
   endtask : pulse
   task automatic check_rd(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
      compares++;
      if ((g & m) !== (e & m))
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g & m, e & m);
      end
   endtask : check_rd
   task automatic check_out(input logic [63:0] g, input logic [63:0] e, input logic [63:0] m);
      compares++;
      if ((g & m) !== (e & m))
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g & m, e & m);
      end
   endtask : check_out
   task automatic conclude();
      $display("errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   function automatic logic [63:0] fv(input logic [15:0] v, input logic dp);
      return 64'h40_0000 | {47'h0, v, dp};
   endfunction : fv
   always @(posedge clock_i)
   begin
      rd_d <= rd_i;
      lk_d <= look_s;
      if (rd_d || lk_d)
      begin
         ent = exp_q.pop_front();
         if (rd_d)
            check_rd(rdata_o, ent[31:0], ent[95:64]);
         else
            check_out({15'h0, servo_enable_o, abs_request_needed_o, motor_o, disp_o},
               ent[63:0], ent[127:64]);
      end
   end
   initial
   begin
      #50000;
      n_errors++;
      conclude();
   end
   // =====================================================
   // Scenarios
   initial
   begin
      void'($urandom(10439));
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(`PMJ_REG_STATUS, 32'h01, 32'h3f);
      rd(`PMJ_REG_JOG_SPEED, 32'd500, 32'hffff);
      rd(8'h24, 32'h0, 32'hffff_ffff);
      look(AR | SE, AR | SE);
      wr(`PMJ_REG_CTRL, 32'h1);
      n = $urandom_range(20, 5);
      repeat (n) pulse(2'b11, 2'b00);
      wr(`PMJ_REG_CTRL, 32'h3);
      repeat (2) pulse(2'b10, 2'b11);
      // Pulses while the clock enable is low must not count
      @(posedge clock_i);
      ce_i <= 1'b0;
      repeat (3) pulse(2'b11, 2'b00);
      @(posedge clock_i);
      ce_i <= 1'b1;
      rd(`PMJ_REG_CNT_A, n, 32'hffff_ffff);
      rd(`PMJ_REG_CNT_B, 32'hffff_fffe, 32'hffff_ffff);
      i_pmj_panel_model.press(3, 4);
      look(fv(n[15:0], 1'b0), MV);
      i_pmj_panel_model.press(2, 4);
      look(fv(16'hfffe, 1'b1), MV);
      i_pmj_panel_model.press(0, 4);
      look(fv(16'hffff, 1'b1), MV);
      i_pmj_panel_model.press(3, 4);
      look(64'h0, 64'h40_0000);
      i_pmj_panel_model.press(4, 4);
      rd(`PMJ_REG_STATUS, 32'h01, 32'h3f);
      i_pmj_panel_model.press(4, 24);
      rd(`PMJ_REG_STATUS, 32'h04, 32'h3f);
      look(64'h0, MF);
      i_pmj_panel_model.press(2, 4);
      look(64'h2_0000, MF);
      i_pmj_panel_model.press(2, 4);
      i_pmj_panel_model.press(1, 4);
      i_pmj_panel_model.press(2, 4);
      look(64'h4_0000, MF);
      i_pmj_panel_model.press(3, 4);
      rd(`PMJ_REG_STATUS, 32'h08, 32'h3f);
      s = 16'($urandom_range(6000, 0));
      wr(`PMJ_REG_JOG_SPEED, {16'h0, s});
      look({20'h0, s, 28'h0}, MS | MM);
      wr(`PMJ_REG_JOG_SPEED, 32'd7000);
      rd(`PMJ_REG_JOG_SPEED, 32'd6000, 32'hffff);
      i_pmj_panel_model.press(4, 4);
      rd(`PMJ_REG_STATUS, 32'h10, 32'h3f);
      look(64'h4000_0000_0000, MM);
      i_pmj_panel_model.key(2, 1'b1);
      look(64'h6000_0000_0000, MM);
      i_pmj_panel_model.key(2, 1'b0);
      i_pmj_panel_model.key(1, 1'b1);
      look(64'h5000_0000_0000, MM);
      i_pmj_panel_model.key(1, 1'b0);
      look(64'h4000_0000_0000 | SE, MM | SE);
      wr(`PMJ_REG_CTRL, 32'h4);
      i_pmj_panel_model.set_term(4'h5);
      look(64'h0, SE);
      i_pmj_panel_model.set_term(4'h7);
      wr(`PMJ_REG_CTRL, 32'h0);
      i_pmj_panel_model.press(4, 4);
      rd(`PMJ_REG_STATUS, 32'h08, 32'h3f);
      look(64'h0, MM);
      wr(`PMJ_REG_CTRL, 32'h4);
      i_pmj_panel_model.set_term(4'hd);
      look(64'h0, SE);
      i_pmj_panel_model.press(3, 4);
      rd(`PMJ_REG_STATUS, 32'h04, 32'h3f);
      look(64'h4_0000, MF);
      look(SE, SE);
      i_pmj_panel_model.set_term(4'h7);
      wr(`PMJ_REG_CTRL, 32'h0);
      wr(`PMJ_REG_TERM_FORCE, 32'h1);
      wr(`PMJ_REG_TERM_LEVEL, 32'h0);
      look(64'h0, SE);
      i_pmj_panel_model.set_term(4'h6);
      wr(`PMJ_REG_TERM_LEVEL, 32'h1);
      look(SE, SE);
      rd(`PMJ_REG_STATUS, 32'h1c0, 32'h3c0);
      wr(`PMJ_REG_TERM_FORCE, 32'h0);
      look(64'h0, SE);
      i_pmj_panel_model.set_term(4'h7);
      wr(`PMJ_REG_ENC_OPT, {28'h0, `PMJ_ENC_AS_INC});
      look(64'h0, AR);
      wr(`PMJ_REG_ENC_OPT, 32'h0);
      look(AR, AR);
      repeat (4) @(posedge clock_i);
      conclude();
   end
endmodule : tb_top
